// ===== bench/rrsf_host_model.sv
// Host side sink model: takes framed bytes from the framer, at full rate or with stalls.
// Assumes the framer holds tx_valid and its byte until a rising edge samples ready high.
`timescale 1ns/1ps

module rrsf_host_model (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  logic [7:0] rx_q[$];
  logic       phase_r;

  initial begin
    tx_ready_out = 1'b0;
    phase_r      = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Ready moves only at the falling edge, so the framer always samples a settled level.
  // A slow host accepts on every other cycle to stretch each frame.
  always @(negedge clk_in) begin
    phase_r      <= ~phase_r;
    tx_ready_out <= slow_in ? phase_r : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Every frame is accepted, however many follow one request.
  always @(posedge clk_in) begin
    if (reset_n_in && tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
      rx_q.push_back(tx_data_in);
    end
  end
endmodule // rrsf_host_model

// ===== bench/test_remote_response_status_framer.sv
// Self-checking bench for the framer: builds expected byte streams and compares them.
// Assumes the host model captures every byte that leaves the framer.
`timescale 1ns/1ps

module test_remote_response_status_framer;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, slow = 1'b0;
  logic        resp_valid_in = 1'b0, resp_addr16_known_in = 1'b0, resp_is_query_in = 1'b0;
  logic [7:0]  resp_frame_id_in = 8'h00, trace_code_in = 8'h00;
  logic [63:0] resp_addr64_in = 64'h0;
  logic [15:0] resp_addr16_in = 16'h0000, resp_cmd_name_in = 16'h0000;
  logic [2:0]  resp_status_in = 3'h0, resp_data_len_in = 3'h0;
  logic [31:0] resp_data_in = 32'h0;
  logic        trace_valid_in = 1'b0, verbose_join_option_in = 1'b0;
  logic [7:0]  trace_data0_in = 8'h00, trace_data1_in = 8'h00;
  logic        command_mode_in = 1'b0, newer_revision_in = 1'b0, tx_ready_in;
  logic        ready_out, tx_valid_out;
  logic [7:0]  tx_data_out;
  logic [7:0]  fd[$], exp_q[$];
  int          error_cnt = 0, num_checks = 0;

  always #12.5 clk_in = ~clk_in;

  rrsf_framer rrsf_framer_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .resp_valid_in(resp_valid_in), .resp_frame_id_in(resp_frame_id_in),
    .resp_addr64_in(resp_addr64_in), .resp_addr16_in(resp_addr16_in),
    .resp_addr16_known_in(resp_addr16_known_in), .resp_cmd_name_in(resp_cmd_name_in),
    .resp_status_in(resp_status_in), .resp_is_query_in(resp_is_query_in),
    .resp_data_len_in(resp_data_len_in), .resp_data_in(resp_data_in),
    .trace_valid_in(trace_valid_in), .trace_code_in(trace_code_in),
    .trace_data0_in(trace_data0_in), .trace_data1_in(trace_data1_in),
    .verbose_join_option_in(verbose_join_option_in), .command_mode_in(command_mode_in),
    .newer_revision_in(newer_revision_in), .tx_ready_in(tx_ready_in), .ready_out(ready_out),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out));

  rrsf_host_model rrsf_host_model_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic fail(input string what);
    error_cnt++;
    $display("BAD %0t %s", $time, what);
    conclude();
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Appends start byte, length, frame data and checksum to the expected stream.
  task automatic wrap();
    logic [7:0] s;
    s = 8'h00;
    foreach (fd[k]) s += fd[k];
    exp_q.push_back(8'h7e);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(fd.size()));
    foreach (fd[k]) exp_q.push_back(fd[k]);
    exp_q.push_back(8'hff - s);
    fd.delete();
  endtask

  // The valid level is held from a falling edge until a rising edge sees ready high.
  task automatic offer(input logic rsp);
    int t;
    @(negedge clk_in);
    if (rsp) resp_valid_in = 1'b1;
    else trace_valid_in = 1'b1;
    t = 0;
    while (ready_out !== 1'b1) begin
      @(negedge clk_in);
      t++;
      if (t > 3000) fail("event never taken");
    end
    @(negedge clk_in);
    resp_valid_in  = 1'b0;
    trace_valid_in = 1'b0;
  endtask

  task automatic send_resp(input logic [7:0] fid, input logic [63:0] a64, input logic [15:0] a16,
      input logic kn, input logic [15:0] cmd, input logic [2:0] st, input logic qy,
      input logic [2:0] n, input logic [31:0] d);
    logic [15:0] sa;
    sa = kn ? a16 : 16'hfffe;
    fd = {8'h97, fid};
    for (int k = 7; k >= 0; k--) fd.push_back(a64[8*k +: 8]);
    fd.push_back(sa[15:8]);
    fd.push_back(sa[7:0]);
    fd.push_back(cmd[15:8]);
    fd.push_back(cmd[7:0]);
    fd.push_back({5'h00, st});
    if (qy) for (int k = int'(n) - 1; k >= 0; k--) fd.push_back(d[8*k +: 8]);
    wrap();
    {resp_frame_id_in, resp_addr64_in, resp_addr16_in, resp_addr16_known_in} = {fid, a64, a16, kn};
    {resp_cmd_name_in, resp_status_in, resp_is_query_in} = {cmd, st, qy};
    {resp_data_len_in, resp_data_in} = {n, d};
    offer(1'b1);
  endtask

  // Mode 0 expects a binary frame, 1 expects nothing, 2 expects the text line.
  task automatic send_trace(input logic [7:0] code, input logic [7:0] d0, input logic [7:0] d1,
      input int mode);
    string s;
    fd = {8'h98, code};
    if (code == 8'h00) fd.push_back(d0);
    if (code == 8'h01) fd = {fd, d0, d1};
    if (mode == 0) wrap();
    fd.delete();
    s = (code == 8'h00) ? "Rejoin\r" : "Stack Status\r";
    if (mode == 2) foreach (s[k]) exp_q.push_back(s[k]);
    {trace_code_in, trace_data0_in, trace_data1_in} = {code, d0, d1};
    offer(1'b0);
  endtask

  task automatic expect_out(input string what);
    int t;
    t = 0;
    while (rrsf_host_model_i.rx_q.size() < exp_q.size()) begin
      @(negedge clk_in);
      t++;
      if (t > 3000) fail("output stalled");
    end
    repeat (8) @(negedge clk_in);
    chk(8'(rrsf_host_model_i.rx_q.size()), 8'(exp_q.size()), "byte count");
    chk({7'h00, ready_out}, 8'h01, "idle after output");
    foreach (exp_q[k]) if (k < rrsf_host_model_i.rx_q.size())
      chk(rrsf_host_model_i.rx_q[k], exp_q[k], what);
    rrsf_host_model_i.rx_q.delete();
    exp_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_query_example();
    slow = 1'b0;
    send_resp(8'h55, 64'h0013a20040522baa, 16'h7d84, 1'b1, 16'h534c, 3'h0, 1'b1, 3'h4,
      32'h40522baa);
    expect_out("query response");
    $display("test_query_example done");
  endtask

  // Five responses back to back through a stalling host, one per outcome code.
  task automatic test_resp_burst();
    slow = 1'b1;
    for (int i = 0; i < 5; i++)
      send_resp(8'(8'ha0 + i), 64'hf1e2d3c4b5a69788 ^ 64'(i), 16'h1234, i != 2, 16'h4e44,
        3'(i), i != 3, 3'(i), 32'hdeadbeef);
    expect_out("response burst");
    $display("test_resp_burst done");
  endtask

  task automatic test_trace_codes();
    logic [7:0] ev[9];
    ev = '{8'h90, 8'h91, 8'h94, 8'h96, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'hab};
    {slow, verbose_join_option_in, command_mode_in} = 3'b110;
    send_trace(8'h00, 8'h03, 8'h00, 0);
    for (int i = 0; i < 9; i++) send_trace(8'h01, 8'(i % 5), ev[i], 0);
    expect_out("trace frames");
    $display("test_trace_codes done");
  endtask

  task automatic test_trace_gating();
    slow = 1'b0;
    verbose_join_option_in = 1'b0;
    send_trace(8'h00, 8'h01, 8'h00, 1);
    send_trace(8'h01, 8'h02, 8'h90, 1);
    {verbose_join_option_in, command_mode_in, newer_revision_in} = 3'b111;
    send_trace(8'h01, 8'h02, 8'h90, 1);
    expect_out("suppressed traces");
    newer_revision_in = 1'b0;
    send_trace(8'h00, 8'h05, 8'h00, 2);
    send_trace(8'h01, 8'h01, 8'h94, 2);
    {command_mode_in, newer_revision_in} = 2'b01;
    send_trace(8'h01, 8'h04, 8'h91, 0);
    expect_out("text and binary traces");
    $display("test_trace_gating done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    test_query_example();
    test_resp_burst();
    test_trace_codes();
    test_trace_gating();
    conclude();
  end
endmodule // test_remote_response_status_framer

// ===== hdl/rrsf_chksum.sv
// Running checksum over the frame data bytes of one outgoing frame.
// Assumes the caller clears it before the first frame data byte and adds each byte once.
`timescale 1ns/1ps

module rrsf_chksum (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clear_in,
  input  wire logic       add_in,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] chk_out
);

  logic [7:0] sum_r;

  // Only the low byte of the sum is kept, so wrap-around is intended.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sum_r <= 8'h00;
    end else if (clear_in) begin
      sum_r <= 8'h00;
    end else if (add_in) begin
      sum_r <= sum_r + byte_in;
    end
  end

  assign chk_out = rrsf_pkg::CHK_BASE - sum_r;

endmodule // rrsf_chksum

// ===== hdl/rrsf_framer.sv
// Top of the remote response and status framer: takes response and trace events,
// serialises framed bytes with a valid/ready handshake toward the serial transmitter.
// Assumes event inputs and mode levels come from logic on the same clock.
`timescale 1ns/1ps

module rrsf_framer (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        resp_valid_in,
  input  wire logic [7:0]  resp_frame_id_in,
  input  wire logic [63:0] resp_addr64_in,
  input  wire logic [15:0] resp_addr16_in,
  input  wire logic        resp_addr16_known_in,
  input  wire logic [15:0] resp_cmd_name_in,
  input  wire logic [2:0]  resp_status_in,
  input  wire logic        resp_is_query_in,
  input  wire logic [2:0]  resp_data_len_in,
  input  wire logic [31:0] resp_data_in,
  input  wire logic        trace_valid_in,
  input  wire logic [7:0]  trace_code_in,
  input  wire logic [7:0]  trace_data0_in,
  input  wire logic [7:0]  trace_data1_in,
  input  wire logic        verbose_join_option_in,
  input  wire logic        command_mode_in,
  input  wire logic        newer_revision_in,
  input  wire logic        tx_ready_in,
  output logic             ready_out,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out
);

  typedef enum logic {RRSF_IDLE, RRSF_SEND} rrsf_state_e;

  rrsf_state_e          st_r;
  rrsf_pkg::rrsf_kind_e kind_r;
  logic                 ready_r;
  logic                 tx_valid_r;
  logic [7:0]           tx_data_r;
  logic [4:0]           idx_r;
  logic [4:0]           last_r;
  logic [7:0]           len_r;
  logic [2:0]           dlen_r;
  logic [7:0]           fid_r;
  logic [63:0]          addr64_r;
  logic [15:0]          addr16_r;
  logic [15:0]          cmd_r;
  logic [7:0]           status_r;
  logic [31:0]          data_r;
  logic [7:0]           code_r;
  logic [7:0]           sd0_r;
  logic [7:0]           sd1_r;
  logic [7:0]           byte_nxt;
  logic [7:0]           chk;
  logic [2:0]           dsel;
  logic [2:0]           trace_nd;
  logic                 take_resp;
  logic                 take_trace;
  logic                 trace_emit;
  logic                 load;
  logic                 add_sum;

  ////////////////////////////////////////////////////////////////////////////////
  // Acceptance and frame capture.

  // A response wins a tie so the command path is never starved by trace chatter.
  assign take_resp  = ready_r && resp_valid_in;
  assign take_trace = ready_r && trace_valid_in && !resp_valid_in;
  // Dropped traces are still consumed, so the trace source never hangs.
  assign trace_emit = verbose_join_option_in && !(command_mode_in && newer_revision_in);
  assign trace_nd   = (trace_code_in == rrsf_pkg::CODE_REJOIN) ? 3'h1 :
                      (trace_code_in == rrsf_pkg::CODE_STACK)  ? 3'h2 : 3'h0;
  assign load       = (st_r == RRSF_SEND) && (!tx_valid_r || tx_ready_in);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r     <= RRSF_IDLE;
      ready_r  <= 1'b1;
      kind_r   <= rrsf_pkg::RRSF_KIND_RESP;
      len_r    <= 8'h00;
      last_r   <= 5'h00;
      dlen_r   <= 3'h0;
      fid_r    <= 8'h00;
      addr64_r <= 64'h0;
      addr16_r <= 16'h0;
      cmd_r    <= 16'h0;
      status_r <= 8'h00;
      data_r   <= 32'h0;
      code_r   <= 8'h00;
      sd0_r    <= 8'h00;
      sd1_r    <= 8'h00;
    end else if (take_resp) begin
      st_r     <= RRSF_SEND;
      ready_r  <= 1'b0;
      kind_r   <= rrsf_pkg::RRSF_KIND_RESP;
      fid_r    <= resp_frame_id_in;
      addr64_r <= resp_addr64_in;
      addr16_r <= resp_addr16_known_in ? resp_addr16_in : rrsf_pkg::ADDR16_UNKNOWN;
      cmd_r    <= resp_cmd_name_in;
      status_r <= {5'h00, resp_status_in};
      data_r   <= resp_data_in;
      dlen_r   <= resp_is_query_in ? resp_data_len_in : 3'h0;
      len_r    <= rrsf_pkg::RESP_FIXED_LEN + (resp_is_query_in ? {5'h00, resp_data_len_in} : 8'h00);
      last_r   <= 5'(rrsf_pkg::RESP_FIXED_LEN + 8'h03 +
                     (resp_is_query_in ? {5'h00, resp_data_len_in} : 8'h00));
    end else if (take_trace && trace_emit) begin
      st_r    <= RRSF_SEND;
      ready_r <= 1'b0;
      code_r  <= trace_code_in;
      sd0_r   <= trace_data0_in;
      sd1_r   <= trace_data1_in;
      if (command_mode_in) begin
        kind_r <= rrsf_pkg::RRSF_KIND_TEXT;
        last_r <= ((trace_code_in == rrsf_pkg::CODE_STACK) ? rrsf_pkg::TXT_STACK_LEN
                                                            : rrsf_pkg::TXT_REJOIN_LEN) - 5'h01;
      end else begin
        kind_r <= rrsf_pkg::RRSF_KIND_TRACE;
        len_r  <= rrsf_pkg::TRACE_FIXED_LEN + {5'h00, trace_nd};
        last_r <= 5'(rrsf_pkg::TRACE_FIXED_LEN + 8'h03 + {5'h00, trace_nd});
      end
    end else if (load && (idx_r == last_r + 5'h01)) begin
      st_r    <= RRSF_IDLE;
      ready_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte selection.

  assign dsel = dlen_r - 3'h1 - 3'(idx_r - rrsf_pkg::OFF_DATA);

  always_comb begin
    byte_nxt = 8'h00;
    if (kind_r == rrsf_pkg::RRSF_KIND_TEXT) begin
      if (code_r == rrsf_pkg::CODE_STACK) begin
        byte_nxt = rrsf_pkg::TXT_STACK[{4'(rrsf_pkg::TXT_STACK_LEN - 5'h01 - idx_r),
                                        3'b000} +: 8];
      end else begin
        byte_nxt = rrsf_pkg::TXT_REJOIN[{3'(rrsf_pkg::TXT_REJOIN_LEN - 5'h01 - idx_r),
                                         3'b000} +: 8];
      end
    end else if (idx_r == 5'h00) begin
      byte_nxt = rrsf_pkg::START_BYTE;
    end else if (idx_r == 5'h01) begin
      byte_nxt = 8'h00;
    end else if (idx_r == 5'h02) begin
      byte_nxt = len_r;
    end else if (idx_r == last_r) begin
      byte_nxt = chk;
    end else if (kind_r == rrsf_pkg::RRSF_KIND_TRACE) begin
      case (idx_r)
        rrsf_pkg::OFF_TYPE:  byte_nxt = rrsf_pkg::TRACE_TYPE;
        rrsf_pkg::OFF_CODE:  byte_nxt = code_r;
        rrsf_pkg::OFF_SDATA: byte_nxt = sd0_r;
        default:             byte_nxt = sd1_r;
      endcase
    end else if (idx_r == rrsf_pkg::OFF_TYPE) begin
      byte_nxt = rrsf_pkg::RESP_TYPE;
    end else if (idx_r == rrsf_pkg::OFF_FID) begin
      byte_nxt = fid_r;
    end else if (idx_r <= rrsf_pkg::OFF_ADDR64_LAST) begin
      byte_nxt = addr64_r[{3'(rrsf_pkg::OFF_ADDR64_LAST - idx_r), 3'b000} +: 8];
    end else if (idx_r < rrsf_pkg::OFF_CMD) begin
      byte_nxt = idx_r[0] ? addr16_r[15:8] : addr16_r[7:0];
    end else if (idx_r < rrsf_pkg::OFF_STATUS) begin
      byte_nxt = idx_r[0] ? cmd_r[15:8] : cmd_r[7:0];
    end else if (idx_r == rrsf_pkg::OFF_STATUS) begin
      byte_nxt = status_r;
    end else begin
      byte_nxt = data_r[{dsel[1:0], 3'b000} +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage and checksum.

  // The length field never exceeds 255, so its high byte is always zero.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idx_r      <= 5'h00;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (st_r == RRSF_IDLE) begin
      idx_r <= 5'h00;
    end else if (load) begin
      if (idx_r == last_r + 5'h01) begin
        tx_valid_r <= 1'b0;
      end else begin
        tx_valid_r <= 1'b1;
        tx_data_r  <= byte_nxt;
        idx_r      <= idx_r + 5'h01;
      end
    end
  end

  assign add_sum = load && (kind_r != rrsf_pkg::RRSF_KIND_TEXT) &&
                   (idx_r >= rrsf_pkg::OFF_TYPE) && (idx_r < last_r);

  rrsf_chksum rrsf_chksum_i (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (st_r == RRSF_IDLE),
    .add_in     (add_sum),
    .byte_in    (byte_nxt),
    .chk_out    (chk)
  );

  assign ready_out    = ready_r;
  assign tx_valid_out = tx_valid_r;
  assign tx_data_out  = tx_data_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_take_resp;
    take_resp;
  endsequence

  sequence s_resp_at(logic [4:0] pos);
    load && (kind_r == rrsf_pkg::RRSF_KIND_RESP) && (idx_r == pos) && (idx_r != last_r);
  endsequence

  AST_RESP_TYPE: assert property (s_resp_at(rrsf_pkg::OFF_TYPE) |=>
    tx_data_r == rrsf_pkg::RESP_TYPE) else $error("Response type byte wrong.");
  AST_FRAME_ID: assert property (s_resp_at(rrsf_pkg::OFF_FID) |=> tx_data_r == fid_r)
    else $error("Frame id not echoed.");
  AST_ADDR64_MSB: assert property (s_resp_at(rrsf_pkg::OFF_ADDR64) |=>
    tx_data_r == addr64_r[63:56]) else $error("64-bit address not MSB first.");
  AST_ADDR16_UNKNOWN: assert property (take_resp && !resp_addr16_known_in |=>
    addr16_r == 16'hfffe) else $error("Unknown short address not 0xFFFE.");
  AST_CMD_NAME: assert property (s_resp_at(rrsf_pkg::OFF_CMD) |=>
    tx_data_r == cmd_r[15:8]) else $error("Command name byte wrong.");
  AST_STATUS: assert property (s_resp_at(rrsf_pkg::OFF_STATUS) |=> tx_data_r == status_r)
    else $error("Command status byte wrong.");
  AST_NO_DATA_ON_SET: assert property (take_resp && !resp_is_query_in |=>
    len_r == 8'h0f && last_r == 5'h12) else $error("Data field not omitted on set.");
  AST_VERBOSE_OFF: assert property (take_trace && !verbose_join_option_in |=>
    st_r == RRSF_IDLE && ready_r) else $error("Trace sent with verbose join off.");
  AST_CMD_SUPPRESS: assert property (take_trace && command_mode_in &&
    newer_revision_in |=> st_r == RRSF_IDLE) else $error("Trace not suppressed in command mode.");
  AST_TRACE_CODE: assert property (load && kind_r == rrsf_pkg::RRSF_KIND_TRACE &&
    idx_r == 5'h04 |=> tx_data_r == code_r) else $error("Status code not at offset 4.");
  AST_REJOIN_LEN: assert property (take_trace && trace_emit && !command_mode_in &&
    trace_code_in == 8'h00 |=> len_r == 8'h03) else $error("Rejoin trace length wrong.");
  AST_TEXT_MODE: assert property (take_trace && trace_emit && command_mode_in |=>
    kind_r == rrsf_pkg::RRSF_KIND_TEXT) else $error("Command mode trace not text.");
  AST_START_BYTE: assert property (s_take_resp |=> ##[1:2] (tx_valid_r && tx_data_r == 8'h7e))
    else $error("Frame start byte missing.");
  AST_LEN_HIGH: assert property (load && (kind_r != rrsf_pkg::RRSF_KIND_TEXT) &&
    idx_r == 5'h01 |=> tx_data_r == 8'h00) else $error("Length high byte not zero.");

endmodule // rrsf_framer

// ===== hdl/rrsf_pkg.sv
// Package for the remote response and status framer: frame codes, offsets and field values.
// Assumes a single 40 MHz clock domain shared by every user of these constants.

package rrsf_pkg;

  typedef enum logic [1:0] {RRSF_KIND_RESP, RRSF_KIND_TRACE, RRSF_KIND_TEXT} rrsf_kind_e;

  localparam logic [7:0]  START_BYTE       = 8'h7e;
  localparam logic [7:0]  REQ_TYPE         = 8'h17;
  localparam logic [7:0]  RESP_TYPE        = 8'h97;
  localparam logic [7:0]  TRACE_TYPE       = 8'h98;
  localparam logic [15:0] ADDR16_UNKNOWN   = 16'hfffe;
  localparam logic [7:0]  CHK_BASE         = 8'hff;

  localparam logic [4:0]  OFF_TYPE         = 5'h03;
  localparam logic [4:0]  OFF_FID          = 5'h04;
  localparam logic [4:0]  OFF_ADDR64       = 5'h05;
  localparam logic [4:0]  OFF_ADDR64_LAST  = 5'h0c;
  localparam logic [4:0]  OFF_ADDR16       = 5'h0d;
  localparam logic [4:0]  OFF_CMD          = 5'h0f;
  localparam logic [4:0]  OFF_STATUS       = 5'h11;
  localparam logic [4:0]  OFF_DATA         = 5'h12;
  localparam logic [4:0]  OFF_CODE         = 5'h04;
  localparam logic [4:0]  OFF_SDATA        = 5'h05;

  localparam logic [7:0]  RESP_FIXED_LEN   = 8'h0f;
  localparam logic [7:0]  TRACE_FIXED_LEN  = 8'h02;
  localparam logic [2:0]  DATA_BYTES       = 3'h4;

  localparam logic [2:0]  ST_OK            = 3'h0;
  localparam logic [2:0]  ST_ERROR         = 3'h1;
  localparam logic [2:0]  ST_BAD_CMD       = 3'h2;
  localparam logic [2:0]  ST_BAD_PARAM     = 3'h3;
  localparam logic [2:0]  ST_TX_FAIL       = 3'h4;

  localparam logic [7:0]  CODE_REJOIN      = 8'h00;
  localparam logic [7:0]  CODE_STACK       = 8'h01;

  localparam logic [7:0]  STK_NO_NETWORK   = 8'h00;
  localparam logic [7:0]  STK_JOINING      = 8'h01;
  localparam logic [7:0]  STK_JOINED       = 8'h02;
  localparam logic [7:0]  STK_NO_PARENT    = 8'h03;
  localparam logic [7:0]  STK_LEAVING      = 8'h04;

  localparam logic [7:0]  EV_NET_UP        = 8'h90;
  localparam logic [7:0]  EV_NET_DOWN      = 8'h91;
  localparam logic [7:0]  EV_JOIN_FAILED   = 8'h94;
  localparam logic [7:0]  EV_MOVE_FAILED   = 8'h96;
  localparam logic [7:0]  EV_ROUTER_INCOMP = 8'h98;
  localparam logic [7:0]  EV_NWK_ID_CHG    = 8'h99;
  localparam logic [7:0]  EV_PAN_CHG       = 8'h9a;
  localparam logic [7:0]  EV_CHANNEL_CHG   = 8'h9b;
  localparam logic [7:0]  EV_NO_BEACONS    = 8'hab;

  localparam logic [4:0]  TXT_REJOIN_LEN   = 5'h07;
  localparam logic [4:0]  TXT_STACK_LEN    = 5'h0d;
  localparam logic [8*7-1:0]  TXT_REJOIN   = "Rejoin\r";
  localparam logic [8*13-1:0] TXT_STACK    = "Stack Status\r";

endpackage
